// [rtl/mtm_timer.sv]
/*
 * 8-bit modulo timer with four clock sources, a 1..256 prescaler and an
 * overflow interrupt request, with wait, stop and debug behaviour.
 * Assumes all inputs synchronous to core_clk except external_count_input,
 * which is synchronised here; the fixed-frequency clock arrives as a
 * one-cycle rising-edge qualifier.
 */
// Function
// - 8-bit up-counter, free or modulo wrap
// - Overflow interrupt request gated by enable
// - Four selectable prescaler input sources
// - Prescaler divides by 1 to 256
// - Keeps counting and interrupting in wait
// - Disabled in stop, no wake-up
// - Deepest stop exit resets the timer
// - Light stop exit by reset resets
// - Light stop exit by interrupt keeps state
// - Debug mode suspends counting
// - Resume after debug unless cleared
// - Selector 1x picks external count input
// - External input synchronised before edge use
// - Status register bit layout
// - Clock config register bit layout
// - Count register read-only
// - Modulo register holds wrap limit
// - Flag set on rollover; interrupt when enabled
// - Flag cleared by read-then-write, clear, modulo
// - Reset halts; clearing halt resumes
// - Source encoding; changes keep counter
`timescale 1ns/10ps
`default_nettype none
module mtm_timer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic fixed_frequency_clock,
	input wire logic external_count_input,
	input wire logic stop_mode,
	input wire logic deepest_stop_exit,
	input wire logic debug_active,
	output logic overflow_irq
);
	typedef enum logic [1:0] {MTM_ARM_IDLE, MTM_ARM_READ} mtm_arm_t;

	logic overflow_flag_ff;
	logic overflow_irq_enable_ff;
	logic counter_halt_ff;
	logic [1:0] source_select_ff;
	logic [3:0] prescale_select_ff;
	logic [7:0] count_ff;
	logic [7:0] modulo_ff;
	logic [7:0] prescale_cnt_ff;
	logic ext_sync1_ff;
	logic ext_sync2_ff;
	logic ext_prev_ff;
	logic [1:0] ext_fill_ff;
	logic ext_ready;
	mtm_arm_t arm_ff;
	logic [7:0] nxt_rdata;
	logic src_tick;
	logic pre_tick;
	logic run;
	logic wrap;
	logic wr_sc;
	logic wr_mod;
	logic wr_clk;
	logic clr_strobe;
	logic timer_reset;

	// Division mask: ratio 2^sel, undefined codes use 256
	function automatic logic [7:0] div_mask(input logic [3:0] sel);
		logic [3:0] eff;
		eff = (sel > mtm_pkg::PRESCALE_MAX_DEFINED) ? mtm_pkg::PRESCALE_MAX_DEFINED : sel;
		div_mask = 8'(9'(1) << eff) - 8'h01;
		if (eff == mtm_pkg::PRESCALE_MAX_DEFINED) begin
			div_mask = 8'hFF;
		end
	endfunction : div_mask

	assign timer_reset = deepest_stop_exit;
	assign wr_sc = reg_wr && (reg_addr == mtm_pkg::OFS_STATUS_CONTROL);
	assign wr_mod = reg_wr && (reg_addr == mtm_pkg::OFS_MODULO_LIMIT);
	assign wr_clk = reg_wr && (reg_addr == mtm_pkg::OFS_CLOCK_CONFIG);
	assign clr_strobe = wr_sc && reg_wdata[mtm_pkg::BIT_COUNTER_CLEAR];
	// Stop disables; debug suspends; wait needs nothing
	assign run = !counter_halt_ff && !stop_mode && !debug_active;

	// External input synchroniser
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_sync1_ff <= 1'b0;
			ext_sync2_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
		end else if (clk_en) begin
			ext_sync1_ff <= external_count_input;
			ext_sync2_ff <= ext_sync1_ff;
			ext_prev_ff <= ext_sync2_ff;
		end
	end

	// Edges only once the synchroniser holds real pin samples
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_fill_ff <= 2'h0;
		end else if (clk_en && ext_fill_ff != 2'h3) begin
			ext_fill_ff <= ext_fill_ff + 2'h1;
		end
	end

	assign ext_ready = (ext_fill_ff == 2'h3);

	// Source select
	always_comb begin
		unique case (source_select_ff)
			mtm_pkg::SRC_BUS: src_tick = 1'b1;
			mtm_pkg::SRC_FIXED: src_tick = fixed_frequency_clock;
			mtm_pkg::SRC_EXT_FALL: src_tick = ext_ready && ext_prev_ff && !ext_sync2_ff;
			mtm_pkg::SRC_EXT_RISE: src_tick = ext_ready && !ext_prev_ff && ext_sync2_ff;
		endcase
	end

	assign pre_tick = run && src_tick && ((prescale_cnt_ff & div_mask(prescale_select_ff))
		== div_mask(prescale_select_ff));
	// Zero modulo gives full range wrap at 8'hFF
	assign wrap = (modulo_ff == 8'h00) ? (count_ff == 8'hFF) : (count_ff == modulo_ff);

	// Prescaler; keeps position across source and ratio changes
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			prescale_cnt_ff <= 8'h00;
		end else if (clk_en) begin
			if (clr_strobe || wr_mod) begin
				prescale_cnt_ff <= 8'h00;
			end else if (run && src_tick) begin
				prescale_cnt_ff <= prescale_cnt_ff + 8'h01;
			end
		end
	end

	// Counter
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			count_ff <= mtm_pkg::RST_COUNT;
		end else if (clk_en) begin
			if (clr_strobe || wr_mod) begin
				count_ff <= mtm_pkg::RST_COUNT;
			end else if (pre_tick) begin
				count_ff <= wrap ? 8'h00 : count_ff + 8'h01;
			end
		end
	end

	// Modulo register
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			modulo_ff <= mtm_pkg::RST_MODULO;
		end else if (clk_en && wr_mod) begin
			modulo_ff <= reg_wdata;
		end
	end

	// Interrupt enable; state held through stop and light stop exit by interrupt
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			overflow_irq_enable_ff <= mtm_pkg::RST_IRQ_ENABLE;
		end else if (clk_en && wr_sc) begin
			overflow_irq_enable_ff <= reg_wdata[mtm_pkg::BIT_IRQ_ENABLE];
		end
	end

	// Counter halt
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			counter_halt_ff <= mtm_pkg::RST_HALT;
		end else if (clk_en && wr_sc) begin
			counter_halt_ff <= reg_wdata[mtm_pkg::BIT_COUNTER_HALT];
		end
	end

	// Source select field
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			source_select_ff <= mtm_pkg::RST_SOURCE;
		end else if (clk_en && wr_clk) begin
			source_select_ff <= reg_wdata[mtm_pkg::SRC_MSB:mtm_pkg::SRC_LSB];
		end
	end

	// Prescale select field
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			prescale_select_ff <= mtm_pkg::RST_PRESCALE;
		end else if (clk_en && wr_clk) begin
			prescale_select_ff <= reg_wdata[mtm_pkg::PRESCALE_MSB:mtm_pkg::PRESCALE_LSB];
		end
	end

	// Clear arming: a status read seeing the flag set arms a clear
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			arm_ff <= MTM_ARM_IDLE;
		end else if (clk_en) begin
			if (reg_rd && reg_addr == mtm_pkg::OFS_STATUS_CONTROL && overflow_flag_ff) begin
				arm_ff <= MTM_ARM_READ;
			end else if (wr_sc || !overflow_flag_ff) begin
				arm_ff <= MTM_ARM_IDLE;
			end
		end
	end

	// Overflow flag; a new rollover wins over the read-then-write clear, but counter clear and modulo write win over it
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			overflow_flag_ff <= 1'b0;
		end else if (clk_en) begin
			if (pre_tick && wrap && !clr_strobe && !wr_mod) begin
				overflow_flag_ff <= 1'b1;
			end else if (clr_strobe || wr_mod) begin
				overflow_flag_ff <= 1'b0;
			end else if (wr_sc && arm_ff == MTM_ARM_READ
				&& !reg_wdata[mtm_pkg::BIT_OVERFLOW_FLAG]) begin
				overflow_flag_ff <= 1'b0;
			end
		end
	end

	// Interrupt request, registered; runs in wait
	always_ff @(posedge core_clk) begin
		if (rst || timer_reset) begin
			overflow_irq <= 1'b0;
		end else if (clk_en) begin
			overflow_irq <= overflow_flag_ff && overflow_irq_enable_ff && !stop_mode;
		end
	end

	// Read mux
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_addr)
			mtm_pkg::OFS_STATUS_CONTROL: begin
				nxt_rdata[mtm_pkg::BIT_OVERFLOW_FLAG] = overflow_flag_ff;
				nxt_rdata[mtm_pkg::BIT_IRQ_ENABLE] = overflow_irq_enable_ff;
				nxt_rdata[mtm_pkg::BIT_COUNTER_CLEAR] = 1'b0;
				nxt_rdata[mtm_pkg::BIT_COUNTER_HALT] = counter_halt_ff;
			end
			mtm_pkg::OFS_CLOCK_CONFIG: begin
				nxt_rdata[mtm_pkg::SRC_MSB:mtm_pkg::SRC_LSB] = source_select_ff;
				nxt_rdata[mtm_pkg::PRESCALE_MSB:mtm_pkg::PRESCALE_LSB] = prescale_select_ff;
			end
			mtm_pkg::OFS_COUNT_VALUE: nxt_rdata = count_ff;
			mtm_pkg::OFS_MODULO_LIMIT: nxt_rdata = modulo_ff;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	// Assertions
	overflow_set_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && pre_tick && wrap && !clr_strobe && !wr_mod && !timer_reset
		|=> overflow_flag_ff && count_ff == 8'h00)
		else $error("overflow flag not set on rollover");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		overflow_irq |-> $past(overflow_flag_ff) && $past(overflow_irq_enable_ff))
		else $error("interrupt without enabled flag");
	stop_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		stop_mode && !wr_mod && !clr_strobe && !timer_reset |=> $stable(count_ff))
		else $error("counter moved during stop");
	debug_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		debug_active && !wr_mod && !clr_strobe && !timer_reset |=> $stable(count_ff))
		else $error("counter moved during debug");
	clear_count_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && (clr_strobe || wr_mod) |=> count_ff == 8'h00 && !overflow_flag_ff)
		else $error("clear did not zero counter and flag");
	halt_reset_a: assert property (@(posedge core_clk)
		rst |=> counter_halt_ff && count_ff == 8'h00)
		else $error("reset did not halt the counter");
	deep_exit_a: assert property (@(posedge core_clk) disable iff (rst)
		timer_reset |=> counter_halt_ff && !overflow_irq_enable_ff && modulo_ff == 8'h00)
		else $error("deep stop exit did not reset timer");
	count_step_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && pre_tick && !wrap && !clr_strobe && !wr_mod && !timer_reset
		|=> count_ff == $past(count_ff) + 8'h01)
		else $error("counter did not advance by one");
	wrap_limit_a: assert property (@(posedge core_clk) disable iff (rst)
		modulo_ff != 8'h00 && $stable(modulo_ff) |-> count_ff <= modulo_ff || $past(wr_mod)
		|| $past(count_ff) > modulo_ff)
		else $error("counter passed modulo limit");
	clear_read_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(reg_rd) && $past(reg_addr) == mtm_pkg::OFS_STATUS_CONTROL && $past(clk_en)
		|-> reg_rdata[3:0] == 4'h0 && !reg_rdata[mtm_pkg::BIT_COUNTER_CLEAR])
		else $error("status reserved or clear bit read nonzero");
	rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(clk_en) && !$past(reg_rd)
		|-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	count_read_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == mtm_pkg::OFS_COUNT_VALUE
		|=> reg_rdata == $past(count_ff))
		else $error("count read returned wrong value");
	mod_read_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == mtm_pkg::OFS_MODULO_LIMIT
		|=> reg_rdata == $past(modulo_ff))
		else $error("modulo read returned wrong value");
	mod_write_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && wr_mod && !timer_reset
		|=> modulo_ff == $past(reg_wdata))
		else $error("modulo write not stored");
	count_wr_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == mtm_pkg::OFS_COUNT_VALUE && !pre_tick && !timer_reset
		|=> $stable(count_ff))
		else $error("count register took a write");
	halt_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		counter_halt_ff && !clr_strobe && !wr_mod && !timer_reset
		|=> $stable(count_ff))
		else $error("counter moved while halted");
	src_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && wr_clk && !pre_tick && !timer_reset
		|=> $stable(count_ff))
		else $error("clock config write disturbed counter");
	flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && wr_sc && arm_ff == MTM_ARM_READ && !reg_wdata[mtm_pkg::BIT_OVERFLOW_FLAG]
		&& !(pre_tick && wrap) && !timer_reset |=> !overflow_flag_ff)
		else $error("armed status write did not clear flag");
	flag_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && overflow_flag_ff && arm_ff == MTM_ARM_IDLE && !clr_strobe && !wr_mod
		&& !timer_reset |=> overflow_flag_ff)
		else $error("flag cleared without prior status read");
	irq_stop_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && stop_mode
		|=> !overflow_irq)
		else $error("interrupt raised during stop");
	irq_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && overflow_flag_ff && overflow_irq_enable_ff && !stop_mode && !timer_reset
		|=> overflow_irq)
		else $error("enabled flag gave no interrupt");
	presc_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!run && !clr_strobe && !wr_mod && !timer_reset
		|=> $stable(prescale_cnt_ff))
		else $error("prescaler moved while suspended");
	src_bus_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && run && source_select_ff == mtm_pkg::SRC_BUS && !clr_strobe && !wr_mod
		&& !timer_reset |=> prescale_cnt_ff == $past(prescale_cnt_ff) + 8'h01)
		else $error("bus clock source did not tick prescaler");
	sync_pipe_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en
		|=> ext_sync2_ff == $past(ext_sync1_ff))
		else $error("external input synchroniser broken");
	cfg_read_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == mtm_pkg::OFS_CLOCK_CONFIG
		|=> reg_rdata[7:6] == 2'h0)
		else $error("clock config upper bits read nonzero");
	deep_count_a: assert property (@(posedge core_clk) disable iff (rst)
		timer_reset
		|=> count_ff == 8'h00 && !overflow_flag_ff && !overflow_irq)
		else $error("stop exit reset left counter or flag");

	wrap_c: cover property (@(posedge core_clk) pre_tick && wrap);
	irq_c: cover property (@(posedge core_clk) overflow_irq);
	ext_c: cover property (@(posedge core_clk) pre_tick && source_select_ff[1]);
	sw_clear_c: cover property (@(posedge core_clk) arm_ff == MTM_ARM_READ && wr_sc);
	deep_exit_c: cover property (@(posedge core_clk) timer_reset && !counter_halt_ff);
endmodule : mtm_timer
`default_nettype wire

// [rtl/mtm_pkg.sv]
/*
 * Package for the 8-bit modulo timer: register offsets, field positions,
 * reset values and encodings.
 * Assumes a plain address/strobe register port with 8-bit data.
 */
package mtm_pkg;
	localparam logic [1:0] OFS_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] OFS_CLOCK_CONFIG = 2'h1;
	localparam logic [1:0] OFS_COUNT_VALUE = 2'h2;
	localparam logic [1:0] OFS_MODULO_LIMIT = 2'h3;
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_COUNTER_CLEAR = 5;
	localparam int BIT_COUNTER_HALT = 4;
	localparam int SRC_MSB = 5;
	localparam int SRC_LSB = 4;
	localparam int PRESCALE_MSB = 3;
	localparam int PRESCALE_LSB = 0;
	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_FIXED = 2'h1;
	localparam logic [1:0] SRC_EXT_FALL = 2'h2;
	localparam logic [1:0] SRC_EXT_RISE = 2'h3;
	localparam logic [3:0] PRESCALE_MAX_DEFINED = 4'h8;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_MODULO = 8'h00;
	localparam logic [1:0] RST_SOURCE = 2'h0;
	localparam logic [3:0] RST_PRESCALE = 4'h0;
	localparam logic RST_HALT = 1'b1;
	localparam logic RST_IRQ_ENABLE = 1'b0;
endpackage : mtm_pkg

// [test/tb_mtm_timer.sv]
/*
 * Self-checking testbench for mtm_timer: registers, overflow, prescaler,
 * clock sources and low-power modes.
 * Assumes mtm_pkg offsets and a read answer one cycle after the strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_mtm_timer;
	localparam logic [1:0] A_SC = mtm_pkg::OFS_STATUS_CONTROL;
	localparam logic [1:0] A_CK = mtm_pkg::OFS_CLOCK_CONFIG;
	localparam logic [1:0] A_CN = mtm_pkg::OFS_COUNT_VALUE;
	localparam logic [1:0] A_MD = mtm_pkg::OFS_MODULO_LIMIT;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ffc = 1'b0;
	logic ext_in = 1'b0;
	logic stop_mode = 1'b0;
	logic dstop = 1'b0;
	logic debug_active = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	logic [7:0] a;
	logic overflow_irq;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	always #2.5 core_clk = ~core_clk;
	mtm_timer i_mtm_timer (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fixed_frequency_clock(ffc), .external_count_input(ext_in), .stop_mode(stop_mode),
		.deepest_stop_exit(dstop), .debug_active(debug_active), .overflow_irq(overflow_irq));
	task automatic summarize;
		if (failures == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] tol);
		logic [7:0] d1;
		logic [7:0] d2;
		d1 = g - e;
		d2 = e - g;
		compares++;
		if ((d1 <= tol) !== 1'b1 && (d2 <= tol) !== 1'b1) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle
	task automatic wr(input logic [1:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] ad);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	task automatic wait_irq;
		for (int n = 0; n < 20 && overflow_irq !== 1'b1; n++) @(posedge core_clk);
		chk({7'h00, overflow_irq}, 8'h01, 8'h00);
	endtask : wait_irq
	task automatic t_regs;
		rd(A_SC); chk(rv, 8'h10, 8'h00);
		rd(A_CK); chk(rv, 8'h00, 8'h00);
		wr(A_CN, 8'h55); idle(20); rd(A_CN); chk(rv, 8'h00, 8'h00);
		wr(A_MD, 8'hA5); rd(A_MD); chk(rv, 8'hA5, 8'h00);
		wr(A_CK, 8'hFF); rd(A_CK); chk(rv, 8'h3F, 8'h00);
		wr(A_SC, 8'hFF); rd(A_SC); chk(rv, 8'h50, 8'h00);
		wr(A_SC, 8'h10);
		wr(A_CK, 8'h00);
	endtask : t_regs
	task automatic t_overflow;
		wr(A_MD, 8'h03);
		wr(A_SC, 8'h40);
		wait_irq();
		wr(A_SC, 8'h50);
		rd(A_CN); chk(rv, 8'h02, 8'h02);
		rd(A_SC); chk(rv, 8'hD0, 8'h00);
		wr(A_SC, 8'h50); idle(2); rd(A_SC); chk(rv, 8'h50, 8'h00);
		chk({7'h00, overflow_irq}, 8'h00, 8'h00);
		wr(A_SC, 8'h40);
		wait_irq();
		wr(A_SC, 8'h70); rd(A_CN); chk(rv, 8'h00, 8'h00);
		rd(A_SC); chk(rv, 8'h50, 8'h00);
		wr(A_SC, 8'h40);
		wait_irq();
		wr(A_SC, 8'h50); wr(A_MD, 8'h03); rd(A_SC); chk(rv, 8'h50, 8'h00);
		wr(A_SC, 8'h10);
	endtask : t_overflow
	task automatic t_prescale;
		for (int p = 0; p < 10; p++) begin
			wr(A_MD, 8'h00);
			wr(A_CK, 8'(p));
			wr(A_SC, 8'h00);
			idle(298);
			wr(A_SC, 8'h10);
			rd(A_CN); chk(rv, 8'(300 >> (p > 8 ? 8 : p)), 8'h01);
		end
	endtask : t_prescale
	task automatic t_sources;
		wr(A_MD, 8'h00);
		for (int s = 1; s < 4; s++) begin
			wr(A_CK, {2'h0, 2'(s), 4'h0});
			wr(A_SC, 8'h00);
			for (int i = 0; i < 10; i++) begin
				@(posedge core_clk); ffc <= 1'b1; ext_in <= ~ext_in;
				@(posedge core_clk); ffc <= 1'b0;
				idle(2);
				@(posedge core_clk); ext_in <= ~ext_in;
				idle(3);
			end
			idle(6);
			wr(A_SC, 8'h10);
			rd(A_CN); chk(rv, 8'(10 * s), 8'h01);
		end
	endtask : t_sources
	task automatic t_modes;
		wr(A_MD, 8'h00);
		wr(A_CK, 8'h00);
		wr(A_SC, 8'h00);
		@(posedge core_clk); debug_active <= 1'b1;
		rd(A_CN); a = rv;
		idle(30); rd(A_CN); chk(rv, a, 8'h00);
		wr(A_MD, 8'h00); rd(A_CN); chk(rv, 8'h00, 8'h00);
		@(posedge core_clk); debug_active <= 1'b0;
		wr(A_SC, 8'h40);
		@(posedge core_clk); stop_mode <= 1'b1;
		rd(A_CN); a = rv;
		idle(300); rd(A_CN); chk(rv, a, 8'h00);
		chk({7'h00, overflow_irq}, 8'h00, 8'h00);
		@(posedge core_clk); stop_mode <= 1'b0;
		idle(2);
		wr(A_SC, 8'h50); rd(A_CN); chk(rv, a + 8'h05, 8'h02);
		rd(A_SC); chk(rv, 8'h50, 8'h00);
		wr(A_MD, 8'h07);
		@(posedge core_clk); dstop <= 1'b1;
		@(posedge core_clk); dstop <= 1'b0;
		rd(A_SC); chk(rv, 8'h10, 8'h00);
		rd(A_MD); chk(rv, 8'h00, 8'h00);
	endtask : t_modes
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		idle(10);
		rst <= 1'b0;
		t_regs();
		t_overflow();
		t_prescale();
		t_sources();
		t_modes();
		summarize();
	end
endmodule : tb_mtm_timer
`default_nettype wire
